// ==== bir_pkg.sv ====
/*
  Constants and types for the buffered bus interface register.
  Assumes a single 100 MHz system clock and a synchronous reset.
*/
package bir_pkg;
  localparam int WIDTH_10 = 10;
  localparam int WIDTH_9 = 9;
  localparam int WIDTH_8 = 8;
  localparam int MAX_WIDTH = 10;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_PTR_W = 2;
  localparam int FIFO_CNT_W = 3;
  localparam logic [MAX_WIDTH-1:0] STORED_RESET = 10'h000;
  localparam int CLK_PERIOD_NS = 10;
  typedef enum logic [1:0] {
    VAR_10 = 2'b00,
    VAR_9 = 2'b01,
    VAR_8 = 2'b11
  } variant_t;
endpackage

// ==== word_fifo.sv ====
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4,
  parameter int PTR_W = 2,
  parameter int CNT_W = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_reg;
  logic [PTR_W-1:0] rd_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = cnt_reg != CNT_W'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ==== bus_interface_register.sv ====
/*
  Buffered bus interface register in 10, 9 and 8 bit variants.
  Assumes all inputs are synchronous to clk; the surroundings resolve
  the bus wire from bus_out and bus_out_oe_n.
*/
`timescale 1ns/1ps
module bus_interface_register
  import bir_pkg::*;
#(
  parameter variant_t VARIANT = VAR_9,
  parameter bit INVERT = 1'b0,
  parameter int WIDTH = WIDTH_9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic register_clock,
  input wire logic load_en_n,
  input wire logic wipe_n,
  input wire logic [2:0] out_ctl_n,
  input wire logic [WIDTH-1:0] bus_in,
  output logic bus_in_ready,
  output logic [WIDTH-1:0] bus_out,
  output logic [WIDTH-1:0] bus_out_oe_n,
  output logic [WIDTH-1:0] stored_bits
);
  logic rclk_last_reg;
  logic rise;
  logic en_active;
  logic wipe_active;
  logic drive;
  logic fifo_valid;
  logic fifo_ready;
  logic [WIDTH-1:0] fifo_data;
  logic [WIDTH-1:0] cap_word;

  // The ten-bit part has neither enable nor clear, so both are ignored.
  assign en_active = (VARIANT == VAR_10) ? 1'b1 : !load_en_n;
  assign wipe_active = (VARIANT == VAR_10) ? 1'b0 : !wipe_n;
  // A rising edge is found by sampling, since register_clock is a pin.
  assign rise = register_clock && !rclk_last_reg;
  // The inverting part stores the complement of the captured word.
  assign cap_word = INVERT ? ~bus_in : bus_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      rclk_last_reg <= 1'b0;
    end else begin
      rclk_last_reg <= register_clock;
    end
  end

  // Captured words queue in a FIFO; a busy FIFO drops bus_in_ready so a
  // source that watches it can stall. A clear empties pending words too.
  word_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(FIFO_DEPTH),
    .PTR_W(FIFO_PTR_W),
    .CNT_W(FIFO_CNT_W)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(wipe_active),
    .in_data(cap_word),
    .in_valid(rise && en_active && !wipe_active),
    .in_ready(fifo_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(1'b1)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_in_ready <= 1'b0;
    end else begin
      bus_in_ready <= fifo_ready;
    end
  end

  // Clear has priority over every load; with enable high nothing is
  // written, so the stored word holds. Output control is not consulted.
  always_ff @(posedge clk) begin
    if (rst) begin
      stored_bits <= STORED_RESET[WIDTH-1:0];
    end else if (wipe_active) begin
      stored_bits <= '0;
    end else if (fifo_valid) begin
      stored_bits <= fifo_data;
    end
  end

  // Eight-bit part: all three controls must be low to drive.
  always_comb begin
    if (VARIANT == VAR_8) begin
      drive = (out_ctl_n == 3'h0);
    end else begin
      drive = !out_ctl_n[0];
    end
  end

  // Outputs are registered from the same next word, so they match the stored word every cycle.
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_out <= '0;
      bus_out_oe_n <= '1;
    end else begin
      bus_out <= wipe_active ? '0 : (fifo_valid ? fifo_data : stored_bits);
      bus_out_oe_n <= {WIDTH{!drive}};
    end
  end
endmodule

// ==== bir_props.sv ====
/*
  Port checker for bus_interface_register.
  Assumes the inverting build, with bit 0 as the output control.
*/
`timescale 1ns/1ps
module bir_props #(parameter int WIDTH = 9) (
  input wire logic clk,
  input wire logic rst,
  input wire logic register_clock,
  input wire logic load_en_n,
  input wire logic wipe_n,
  input wire logic [2:0] out_ctl_n,
  input wire logic [WIDTH-1:0] bus_in,
  input wire logic [WIDTH-1:0] bus_out,
  input wire logic [WIDTH-1:0] bus_out_oe_n,
  input wire logic [WIDTH-1:0] stored_bits
);
  logic rc_reg;
  wire tk = register_clock & ~rc_reg & ~load_en_n & wipe_n;
  // History clears in reset, so a high clock at release counts as a rise.
  always_ff @(posedge clk) rc_reg <= rst ? 1'b0 : register_clock;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ld;
    tk ##1 wipe_n |=> stored_bits == ~$past(bus_in, 2);
  endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_hd; !tk ##1 wipe_n |=> $stable(stored_bits); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_cl; !wipe_n |=> stored_bits == '0 && bus_out == '0; endproperty
  a_cl: assert property (p_cl) else $error("clear");
  property p_nl; !wipe_n |=> ##1 stored_bits == '0; endproperty
  a_nl: assert property (p_nl) else $error("load in clear");
  property p_of; out_ctl_n[0] |=> &bus_out_oe_n; endproperty
  a_of: assert property (p_of) else $error("float");
  property p_on; !out_ctl_n[0] |=> bus_out_oe_n == '0; endproperty
  a_on: assert property (p_on) else $error("drive");
  property p_mr; bus_out == stored_bits; endproperty
  a_mr: assert property (p_mr) else $error("output");
  property p_rs; $rose(wipe_n) |-> stored_bits == '0; endproperty
  a_rs: assert property (p_rs) else $error("clear held");
  c_ld: cover property (tk);
  c_cl: cover property (!wipe_n);
  c_of: cover property (out_ctl_n[0] && !wipe_n);
endmodule
bind bus_interface_register bir_props #(.WIDTH(WIDTH)) i_bir_props (.clk,
  .rst, .register_clock, .load_en_n, .wipe_n, .out_ctl_n, .bus_in,
  .bus_out, .bus_out_oe_n, .stored_bits);

// ==== bir_sink.sv ====
/*
  Destination bus: one pulled-up wire per bit.
  Assumes bus_out_oe_n is low while the register drives.
*/
`timescale 1ns/1ps
module bir_sink #(parameter int WIDTH = 9) (
  input wire logic [WIDTH-1:0] bus_out,
  input wire logic [WIDTH-1:0] bus_out_oe_n,
  output wire logic [WIDTH-1:0] bus_wire
);
  // Released bits go to the pull-up level.
  assign bus_wire = bus_out | bus_out_oe_n;
endmodule

// ==== bus_interface_register_bench.sv ====
/*
  Bench for the inverting 9-bit register.
  Assumes bir_sink pulls released bits high.
*/
`timescale 1ns/1ps
module bus_interface_register_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic register_clock = 1'b0;
  logic load_en_n = 1'b0;
  logic wipe_n = 1'b1;
  logic note = 1'b0;
  logic bus_in_ready;
  logic [1:0] pend = 2'h0;
  logic [2:0] out_ctl_n = 3'h0;
  logic [8:0] bus_in = 9'h000;
  logic [8:0] last = 9'h000;
  logic [8:0] bus_out, bus_out_oe_n, stored_bits, bus_wire;
  logic [8:0] q[$];
  int mismatches = 0;
  int total_checks = 0;
  initial forever #5 clk = ~clk;
  bus_interface_register #(.INVERT(1'b1)) i_bus_interface_register (.clk,
    .rst, .register_clock, .load_en_n, .wipe_n, .out_ctl_n, .bus_in,
    .bus_in_ready, .bus_out, .bus_out_oe_n, .stored_bits);
  bir_sink i_bir_sink (.bus_out, .bus_out_oe_n, .bus_wire);
  task automatic chk(string n, logic [8:0] s, logic [8:0] e);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic ld(logic [8:0] d, logic e);
    @(posedge clk) #1;
    register_clock = 1'b1;
    bus_in = d;
    load_en_n = e;
    note = ~e;
    if (!e) q.push_back(~d);
    if (!e) last = ~d;
    @(posedge clk) #1;
    register_clock = 1'b0;
    note = 1'b0;
  endtask
  always @(posedge clk) begin
    pend <= {pend[0], note};
    if (pend[1]) chk("stored", stored_bits, q.pop_front());
  end
  initial begin
    void'($urandom(66));
    repeat (4) @(posedge clk) #1;
    rst = 1'b0;
    repeat (16) ld(9'($urandom), 1'($urandom));
    repeat (3) @(posedge clk) #1;
    chk("hold", stored_bits, last);
    chk("ready", {8'h00, bus_in_ready}, 9'h001);
    $display("load test done");
    for (int i = 0; i < 4; i++) begin
      out_ctl_n = 3'(i);
      repeat (2) @(posedge clk) #1;
      chk("bus", bus_wire, i[0] ? 9'h1ff : last);
    end
    $display("bus test done");
    // The rise lands inside the clear, so it must be refused.
    wipe_n = 1'b0;
    register_clock = 1'b1;
    repeat (2) @(posedge clk) #1;
    wipe_n = 1'b1;
    out_ctl_n = 3'h6;
    repeat (2) @(posedge clk) #1;
    chk("clear", bus_wire, 9'h000);
    $display("clear test done");
    close_out;
  end
  initial begin
    repeat (400) @(posedge clk);
    mismatches++;
    close_out;
  end
endmodule
